// [inc/adc_seq_pkg.sv]
// Behaviour
// - With gain trim on, each result is multiplied by trim code over 8388608.
// - Trim uses a shift-and-add on decimated clock, delaying data-ready 23 periods.
// - Next conversion runs during trim delay; conversion period is not lengthened.
// - Turning trim on leaves held result alone; only the next result is trimmed.
// - A new trim code affects only the next result, not the held one.
// - Run select 0X: one conversion or sequence cycle, then shutdown, state field 00.
// - Run select 10: one conversion or sequence cycle, then standby, state field 10.
// - Run select 11 in sequence mode: repeat cycles with inter-cycle delay; field stays 11.
// - Single shot takes one conversion period, or two with auto-zero swap.
// - In single shot, data-ready stays asserted until the host reads the result.
// - Continuous single-input: no filter reset; results every conversion period.
// - Auto-zero swap makes continuous mode back-to-back single shots, spacing doubled.
// - Sequence mode converts each selected channel once per cycle, always single shot.
// - Writing the run select mid-conversion never resets or restarts it.
// - In sequence mode the input-selector register is ignored for input choice.
// - Each sequence conversion raises data-ready and overwrites the single result.
// - Reset in single-input mode; nonzero channel mask enters sequence mode.
// - Sequence starts on state-field write of 11 or restart; holds 11 until done.
// - Channels convert from highest mask bit down to lowest.
// - Intra-cycle wait code: 000 gives 0, 001..111 give 8 doubling to 512.
package adc_seq_pkg;
	// =======================================================
	// register offsets
	localparam logic [3:0]  OFS_RESULT    = 4'h0;
	localparam logic [3:0]  OFS_ADC_MODE  = 4'h1;
	localparam logic [3:0]  OFS_THIRD_CONFIG_REGISTER   = 4'h4;
	localparam logic [3:0]  OFS_INPUT_SEL = 4'h6;
	localparam logic [3:0]  OFS_SCAN      = 4'h7;
	localparam logic [3:0]  OFS_TIMER     = 4'h8;
	localparam logic [3:0]  OFS_GAIN      = 4'ha;
	// =======================================================
	// field positions
	localparam int          RUN_SEL_MSB   = 7;
	localparam int          AZ_SWAP_BIT   = 2;
	localparam int          GTRIM_EN_BIT  = 0;
	localparam int          WAIT_MSB      = 22;
	// =======================================================
	// reset values
	localparam logic [1:0]  RST_ADC_MODE  = 2'h0;
	localparam logic [7:0]  RST_THIRD_CONFIG_REGISTER   = 8'h00;
	localparam logic [7:0]  RST_INPUT_SEL = 8'h01;
	localparam logic [23:0] RST_SCAN      = 24'h000000;
	localparam logic [23:0] RST_TIMER     = 24'h000000;
	localparam logic [23:0] RST_GAIN      = 24'h800000;
	localparam logic [23:0] RST_RESULT    = 24'h000000;
	// =======================================================
	// gain trim scale, and timing in decimated clock periods
	localparam int          GTRIM_SCALE        = 8388608;
	localparam int          GTRIM_SHIFT        = $clog2(GTRIM_SCALE);
	localparam logic [4:0]  GTRIM_LATENCY      = 5'd23;
	localparam logic [23:0] CONV_PERIOD_TICKS  = 24'h000040;
	localparam logic [9:0]  INTRA_WAIT_BASE    = 10'h004;
	localparam logic [2:0]  DRDY_AUTO_CLR_TICKS = 3'h4;
	// =======================================================
	// converter state field codes
	localparam logic [1:0]  MODE_SHUTDOWN = 2'b00;
	localparam logic [1:0]  MODE_STANDBY  = 2'b10;
	localparam logic [1:0]  MODE_CONVERT  = 2'b11;
	// sequence channel to input-selector code, index = mask bit
	localparam logic [15:0][7:0] SCAN_MUX_CODE = {
		8'h88, 8'hf8, 8'h98, 8'hde, 8'h67, 8'h45, 8'h23, 8'h01,
		8'h78, 8'h68, 8'h58, 8'h48, 8'h38, 8'h28, 8'h18, 8'h08};
	// =======================================================
	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE       = 2'b00,
		ST_CONVERT    = 2'b01,
		ST_INTRA_WAIT = 2'b10,
		ST_CYCLE_WAIT = 2'b11
	} seq_state_t;
endpackage : adc_seq_pkg

// [hw/adc_conversion_sequencer.sv]
`timescale 1ns/1ps
module adc_conversion_sequencer (
	input  wire logic        i_clk_sys,    // system clock, 40 MHz
	input  wire logic        i_rst,        // async reset, active high
	input  wire logic        i_decimated_master_clock,      // decimated master clock pin
	input  wire logic [23:0] i_adc_raw,    // filter output, valid at conversion end
	input  wire logic [3:0]  i_reg_addr,   // register offset
	input  wire logic        i_reg_wr,     // write strobe, one cycle
	input  wire logic        i_reg_rd,     // read strobe, one cycle
	input  wire logic [23:0] i_reg_wdata,  // write data
	input  wire logic        i_cmd_restart, // fast restart command pulse
	output logic      [23:0] o_reg_rdata,  // read data, one cycle after strobe
	output logic             o_irq_n,      // data ready, active low
	output logic      [1:0]  o_adc_mode,   // converter state field
	output logic      [7:0]  o_mux_sel,    // analog input selection
	output logic             o_filter_reset, // filter reset pulse
	output logic             o_converting  // conversion in progress
);
	import adc_seq_pkg::*;

	// =======================================================
	// decimated clock sampling
	logic dm_s1;
	logic dm_s2;
	logic dm_s3;
	logic tick;

	// two-flop synchroniser plus edge history
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			dm_s1 <= 1'b0;
			dm_s2 <= 1'b0;
			dm_s3 <= 1'b0;
		end else begin
			dm_s1 <= i_decimated_master_clock;
			dm_s2 <= dm_s1;
			dm_s3 <= dm_s2;
		end
	end

	// one pulse per rising edge of the decimated clock
	assign tick = dm_s2 & ~dm_s3;

	// highest set bit of a channel mask
	function automatic logic [3:0] top_chan(input logic [15:0] m);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (m[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction : top_chan

	// =======================================================
	// registers and sequencer
	seq_state_t  state, next_state;
	logic [1:0]  adc_mode, next_adc_mode;
	logic [7:0]  third_config_register, next_third_config_register;
	logic [7:0]  input_sel, next_input_sel;
	logic [23:0] scan, next_scan;
	logic [23:0] timer_val, next_timer_val;
	logic [23:0] gain, next_gain;
	logic [23:0] cnt, next_cnt;
	logic [15:0] remain, next_remain;
	logic [3:0]  chan, next_chan;
	logic [7:0]  mux_sel, next_mux_sel;
	logic        filt_rst, next_filt_rst;
	logic [23:0] rdata, next_rdata;
	logic        cap;
	logic [23:0] result;
	logic        drdy;

	logic [1:0]  run_sel;
	logic        az_swap;
	logic        scan_on;
	logic [2:0]  wait_code;
	logic [23:0] conv_len;
	logic [23:0] wait_len;

	assign run_sel   = third_config_register[RUN_SEL_MSB -: 2];
	assign az_swap   = third_config_register[AZ_SWAP_BIT];
	assign scan_on   = |scan[15:0];
	assign wait_code = scan[WAIT_MSB -: 3];
	// doubled period when inputs are swapped for auto-zero
	assign conv_len  = az_swap ? (CONV_PERIOD_TICKS << 1) : CONV_PERIOD_TICKS;
	// 0 for code 000, else 8 << (code-1)
	assign wait_len  = (wait_code == 3'h0) ? 24'h000000 : {14'h0000, INTRA_WAIT_BASE << wait_code};

	// next values of the register file and sequencer
	always_comb begin
		logic [15:0] rem;
		logic        start;
		logic        abort;
		rem            = remain;
		start          = 1'b0;
		abort          = 1'b0;
		next_state     = state;
		next_adc_mode  = adc_mode;
		next_third_config_register   = third_config_register;
		next_input_sel = input_sel;
		next_scan      = scan;
		next_timer_val = timer_val;
		next_gain      = gain;
		next_cnt       = cnt;
		next_remain    = remain;
		next_chan      = chan;
		next_filt_rst  = 1'b0;
		next_rdata     = rdata;
		cap            = 1'b0;
		unique case (state)
			ST_IDLE: begin
			end
			ST_CONVERT: begin
				if (tick) begin
					if (cnt == conv_len - 24'h000001) begin
						cap      = 1'b1;
						next_cnt = 24'h000000;
						if (scan_on) begin
							rem = remain & ~(16'h0001 << chan);
							if (rem != 16'h0000) begin
								next_remain = rem;
								next_chan   = top_chan(rem);
								if (wait_len != 24'h000000) begin
									next_state = ST_INTRA_WAIT;
								end else begin
									next_filt_rst = 1'b1;
								end
							end else if (run_sel == MODE_CONVERT) begin
								if (timer_val != 24'h000000) begin
									next_state = ST_CYCLE_WAIT;
								end else begin
									next_remain   = scan[15:0];
									next_chan     = top_chan(scan[15:0]);
									next_filt_rst = 1'b1;
								end
							end else begin
								next_state    = ST_IDLE;
								next_adc_mode = run_sel[1] ? MODE_STANDBY : MODE_SHUTDOWN;
							end
						end else if (run_sel == MODE_CONVERT) begin
							next_filt_rst = az_swap;
						end else begin
							next_state    = ST_IDLE;
							next_adc_mode = run_sel[1] ? MODE_STANDBY : MODE_SHUTDOWN;
						end
					end else begin
						next_cnt = cnt + 24'h000001;
					end
				end
			end
			ST_INTRA_WAIT: begin
				if (tick) begin
					if (cnt == wait_len - 24'h000001) begin
						next_state    = ST_CONVERT;
						next_cnt      = 24'h000000;
						next_filt_rst = 1'b1;
					end else begin
						next_cnt = cnt + 24'h000001;
					end
				end
			end
			ST_CYCLE_WAIT: begin
				if (tick) begin
					if (cnt == timer_val - 24'h000001) begin
						next_state    = ST_CONVERT;
						next_cnt      = 24'h000000;
						next_remain   = scan[15:0];
						next_chan     = top_chan(scan[15:0]);
						next_filt_rst = 1'b1;
					end else begin
						next_cnt = cnt + 24'h000001;
					end
				end
			end
		endcase
		// host writes; the sequencer looks at run select only at conversion end
		if (i_reg_wr) begin
			unique case (i_reg_addr)
				OFS_ADC_MODE: begin
					next_adc_mode = i_reg_wdata[1:0];
					start         = (i_reg_wdata[1:0] == MODE_CONVERT);
					abort         = (i_reg_wdata[1:0] != MODE_CONVERT);
				end
				OFS_THIRD_CONFIG_REGISTER:   next_third_config_register   = i_reg_wdata[7:0];
				OFS_INPUT_SEL: next_input_sel = i_reg_wdata[7:0];
				OFS_SCAN:      next_scan      = i_reg_wdata;
				OFS_TIMER:     next_timer_val = i_reg_wdata;
				OFS_GAIN:      next_gain      = i_reg_wdata;
				default: begin
				end
			endcase
		end
		if (i_cmd_restart) begin
			start         = 1'b1;
			next_adc_mode = MODE_CONVERT;
		end
		if (start) begin
			next_state    = ST_CONVERT;
			next_cnt      = 24'h000000;
			next_remain   = scan[15:0];
			next_chan     = top_chan(scan[15:0]);
			next_filt_rst = 1'b1;
		end else if (abort) begin
			next_state = ST_IDLE;
		end
		// input selection follows the sequence channel in sequence mode
		next_mux_sel = scan_on ? SCAN_MUX_CODE[next_chan] : input_sel;
		// read data, unmapped offsets read zero
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				OFS_RESULT:    next_rdata = result;
				OFS_ADC_MODE:  next_rdata = {22'h000000, adc_mode};
				OFS_THIRD_CONFIG_REGISTER:   next_rdata = {16'h0000, third_config_register};
				OFS_INPUT_SEL: next_rdata = {16'h0000, input_sel};
				OFS_SCAN:      next_rdata = scan;
				OFS_TIMER:     next_rdata = timer_val;
				OFS_GAIN:      next_rdata = gain;
				default:       next_rdata = 24'h000000;
			endcase
		end
	end

	// register file and sequencer state
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state     <= ST_IDLE;
			adc_mode  <= RST_ADC_MODE;
			third_config_register   <= RST_THIRD_CONFIG_REGISTER;
			input_sel <= RST_INPUT_SEL;
			scan      <= RST_SCAN;
			timer_val <= RST_TIMER;
			gain      <= RST_GAIN;
			cnt       <= 24'h000000;
			remain    <= 16'h0000;
			chan      <= 4'h0;
			mux_sel   <= RST_INPUT_SEL;
			filt_rst  <= 1'b0;
			rdata     <= 24'h000000;
		end else begin
			state     <= next_state;
			adc_mode  <= next_adc_mode;
			third_config_register   <= next_third_config_register;
			input_sel <= next_input_sel;
			scan      <= next_scan;
			timer_val <= next_timer_val;
			gain      <= next_gain;
			cnt       <= next_cnt;
			remain    <= next_remain;
			chan      <= next_chan;
			mux_sel   <= next_mux_sel;
			filt_rst  <= next_filt_rst;
			rdata     <= next_rdata;
		end
	end

	// =======================================================
	// gain trim multiplier and result register
	logic               busy, next_busy;
	logic [4:0]         step, next_step;
	logic signed [48:0] acc, next_acc;
	logic [23:0]        raw_hold, next_raw_hold;
	logic [23:0]        code_hold, next_code_hold;
	logic [23:0]        next_result;
	logic               next_drdy;
	logic [2:0]         drdy_cnt, next_drdy_cnt;

	// serial shift-and-add, runs alongside the next conversion
	always_comb begin
		logic signed [48:0] addend;
		logic signed [48:0] acc_step;
		logic signed [48:0] prod;
		logic signed [48:0] scaled;
		logic               deliver;
		logic [23:0]        value;
		addend         = 49'(signed'(raw_hold)) <<< GTRIM_SHIFT;
		acc_step       = (acc + (code_hold[step] ? addend : 49'sd0)) >>> 1;
		prod           = acc_step + (code_hold[23] ? addend : 49'sd0);
		scaled         = prod >>> GTRIM_SHIFT;
		deliver        = 1'b0;
		value          = result;
		next_busy      = busy;
		next_step      = step;
		next_acc       = acc;
		next_raw_hold  = raw_hold;
		next_code_hold = code_hold;
		next_result    = result;
		next_drdy      = drdy;
		next_drdy_cnt  = drdy_cnt;
		if (busy && tick) begin
			if (step == GTRIM_LATENCY - 5'd1) begin
				next_busy = 1'b0;
				deliver   = 1'b1;
				// saturate to signed 24 bits
				if (scaled > 49'sh7fffff) begin
					value = 24'h7fffff;
				end else if (scaled < -49'sh800000) begin
					value = 24'h800000;
				end else begin
					value = scaled[23:0];
				end
			end else begin
				next_acc  = acc_step;
				next_step = step + 5'd1;
			end
		end
		if (cap) begin
			if (third_config_register[GTRIM_EN_BIT]) begin
				next_busy      = 1'b1;
				next_step      = 5'd0;
				next_acc       = 49'sd0;
				next_raw_hold  = i_adc_raw;
				next_code_hold = gain;
			end else begin
				deliver = 1'b1;
				value   = i_adc_raw;
			end
		end
		// auto clear only in continuous single-input mode
		if (drdy && tick && !scan_on && run_sel == MODE_CONVERT) begin
			if (drdy_cnt == DRDY_AUTO_CLR_TICKS - 3'd1) begin
				next_drdy = 1'b0;
			end else begin
				next_drdy_cnt = drdy_cnt + 3'd1;
			end
		end
		if (i_reg_rd && i_reg_addr == OFS_RESULT) begin
			next_drdy = 1'b0;
		end
		// a new result wins over a clear in the same cycle
		if (deliver) begin
			next_result   = value;
			next_drdy     = 1'b1;
			next_drdy_cnt = 3'd0;
		end
	end

	// multiplier and result state
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			busy      <= 1'b0;
			step      <= 5'd0;
			acc       <= 49'sd0;
			raw_hold  <= 24'h000000;
			code_hold <= 24'h000000;
			result    <= RST_RESULT;
			drdy      <= 1'b0;
			drdy_cnt  <= 3'd0;
		end else begin
			busy      <= next_busy;
			step      <= next_step;
			acc       <= next_acc;
			raw_hold  <= next_raw_hold;
			code_hold <= next_code_hold;
			result    <= next_result;
			drdy      <= next_drdy;
			drdy_cnt  <= next_drdy_cnt;
		end
	end

	// =======================================================
	// outputs
	assign o_reg_rdata    = rdata;
	assign o_irq_n        = ~drdy;
	assign o_adc_mode     = adc_mode;
	assign o_mux_sel      = mux_sel;
	assign o_filter_reset = filt_rst;
	assign o_converting   = (state == ST_CONVERT);
endmodule : adc_conversion_sequencer

// [sim/adc_conversion_sequencer_sva.sv]
`timescale 1ns/1ps
module adc_seq_checker
	import adc_seq_pkg::*;
(
	input  wire logic        i_clk_sys,      // clock
	input  wire logic        i_rst,          // reset
	input  wire logic        i_decimated_master_clock,        // decimated clock
	input  wire logic [3:0]  i_reg_addr,     // offset
	input  wire logic        i_reg_wr,       // write
	input  wire logic        i_reg_rd,       // read
	input  wire logic [23:0] i_reg_wdata,    // write data
	input  wire logic        i_cmd_restart,  // restart
	input  wire logic        o_irq_n,        // data ready
	input  wire logic [1:0]  o_adc_mode,     // state field
	input  wire logic        o_filter_reset, // filter reset
	input  wire logic        o_converting    // converting
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);
	// ====
	// helper: counts decimated clock edges while converting
	logic       dm_q, next_dm_q, mwr_q, next_mwr_q;
	logic [7:0] ticks, next_ticks;
	always_comb begin
		next_dm_q = i_decimated_master_clock;
		next_mwr_q = i_reg_wr && (i_reg_addr == OFS_ADC_MODE);
		next_ticks = o_converting ? ticks + {7'h00, i_decimated_master_clock & ~dm_q} : 8'h00;
	end
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			dm_q <= 1'b0;
			mwr_q <= 1'b0;
			ticks <= 8'h00;
		end else begin
			dm_q <= next_dm_q;
			mwr_q <= next_mwr_q;
			ticks <= next_ticks;
		end
	end
	// ====
	// assertions
	a_conv_ticks: assert property (
		$fell(o_converting) && !mwr_q |-> ticks[5:0] inside {6'h3f, 6'h00, 6'h01})
		else $error("conversion length not a whole period");
	a_start_convert: assert property (
		i_reg_wr && i_reg_addr == OFS_ADC_MODE && i_reg_wdata[1:0] == MODE_CONVERT
		|=> o_converting && o_adc_mode == MODE_CONVERT) else $error("start write did not start");
	a_restart_cmd: assert property (
		i_cmd_restart |=> o_converting && o_adc_mode == MODE_CONVERT) else $error("restart did not start");
	a_stop_standby: assert property (
		i_reg_wr && i_reg_addr == OFS_ADC_MODE && i_reg_wdata[1:0] == MODE_STANDBY
		|=> !o_converting && o_adc_mode == MODE_STANDBY) else $error("standby write ignored");
	a_stop_shutdown: assert property (
		i_reg_wr && i_reg_addr == OFS_ADC_MODE && i_reg_wdata[1:0] == MODE_SHUTDOWN
		|=> !o_converting && o_adc_mode == MODE_SHUTDOWN) else $error("shutdown write ignored");
	a_conv_field: assert property (
		o_converting |-> o_adc_mode == MODE_CONVERT) else $error("field not 11 while converting");
	a_reset_start: assert property (
		$rose(o_converting) |-> o_filter_reset) else $error("no filter reset at start");
	a_read_clears: assert property (
		i_reg_rd && i_reg_addr == OFS_RESULT |=> o_irq_n) else $error("result read left data ready");
endmodule : adc_seq_checker

bind adc_conversion_sequencer adc_seq_checker u_chk (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_decimated_master_clock(i_decimated_master_clock), .i_reg_addr(i_reg_addr),
	.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .i_cmd_restart(i_cmd_restart),
	.o_irq_n(o_irq_n), .o_adc_mode(o_adc_mode), .o_filter_reset(o_filter_reset), .o_converting(o_converting)
);

// [sim/adc_host_model.sv]
`timescale 1ns/1ps
module adc_host_model (
	input  wire logic        i_clk,     // system clock
	input  wire logic [23:0] i_rdata,   // read data
	output logic      [3:0]  o_addr,    // offset
	output logic             o_wr,      // write pulse
	output logic             o_rd,      // read pulse
	output logic      [23:0] o_wdata,   // write data
	output logic             o_restart  // restart pulse
);
	initial begin
		o_addr = 4'h0;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 24'h000000;
		o_restart = 1'b0;
	end
	// one-cycle write, launched off the sampling edge
	task automatic wr(input logic [3:0] a, input logic [23:0] d);
		@(negedge i_clk);
		o_addr = a;
		o_wdata = d;
		o_wr = 1'b1;
		@(negedge i_clk);
		o_wr = 1'b0;
	endtask : wr
	// one-cycle read, data taken once the strobe edge has passed
	task automatic rd(input logic [3:0] a, output logic [23:0] d);
		@(negedge i_clk);
		o_addr = a;
		o_rd = 1'b1;
		@(negedge i_clk);
		o_rd = 1'b0;
		d = i_rdata;
	endtask : rd
	// fast restart pulse
	task automatic restart();
		@(negedge i_clk);
		o_restart = 1'b1;
		@(negedge i_clk);
		o_restart = 1'b0;
	endtask : restart
endmodule : adc_host_model

// [sim/adc_conversion_sequencer_tb.sv]
`timescale 1ns/1ps
module adc_conversion_sequencer_tb;
	import adc_seq_pkg::*;
	typedef struct packed {logic w; logic [3:0] a; logic [23:0] d; logic [23:0] e;} row_t;
	// ====
	// stimulus and design
	logic        clk, rst, decimated_master_clock, rstrt, wr, rd, irq_n, frst, conv;
	logic [23:0] raw, wdata, rdata, v;
	logic [3:0]  addr;
	logic [1:0]  mode;
	logic [7:0]  input_selector;
	int          n_errors, n_compared, cyc, t0, t1, nfr, n0;
	int          sp[7] = '{512, 576, 576, 512, 576, 576, 640};
	logic [7:0]  nx[7] = '{8'h01, 8'h08, 8'h88, 8'h01, 8'h08, 8'h08, 8'h01};
	row_t        rows[9] = '{
		'{1'b0, 4'h0, 24'h000000, 24'h000000}, '{1'b0, 4'h6, 24'h000000, 24'h000001},
		'{1'b0, 4'ha, 24'h000000, 24'h800000}, '{1'b0, 4'h1, 24'h000000, 24'h000000},
		'{1'b0, 4'h7, 24'h000000, 24'h000000}, '{1'b1, 4'h6, 24'h00005a, 24'h00005a},
		'{1'b1, 4'h0, 24'hffffff, 24'h000000}, '{1'b1, 4'h2, 24'h123456, 24'h000000},
		'{1'b1, 4'ha, 24'h400000, 24'h400000}};
	initial clk = 1'b0;
	always #12.5 clk = ~clk;
	initial decimated_master_clock = 1'b0;
	always #100 decimated_master_clock = ~decimated_master_clock;
	// cycle stamp and filter reset tally
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (frst === 1'b1) nfr <= nfr + 1;
	end
	adc_host_model host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd),
		.o_wdata(wdata), .o_restart(rstrt));
	adc_conversion_sequencer uut (.i_clk_sys(clk), .i_rst(rst), .i_decimated_master_clock(decimated_master_clock), .i_adc_raw(raw),
		.i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .i_cmd_restart(rstrt),
		.o_reg_rdata(rdata), .o_irq_n(irq_n), .o_adc_mode(mode), .o_mux_sel(input_selector),
		.o_filter_reset(frst), .o_converting(conv));
	// ====
	// checks and waits
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
		n_compared++;
		if (g < lo || g > hi) begin
			n_errors++;
			$display("MISMATCH %s exp %0d..%0d got %0d", nm, lo, hi, g);
		end
	endtask : chk_rng
	// waits for the next falling edge of data ready and stamps it
	task automatic wait_irq();
		int k;
		k = 0;
		while (irq_n !== 1'b1 && k < 3000) begin
			@(negedge clk);
			k++;
		end
		while (irq_n !== 1'b0 && k < 3000) begin
			@(negedge clk);
			k++;
		end
		if (k >= 3000) begin
			n_errors++;
			$display("MISMATCH irq_wait exp low got timeout");
		end
		t0 = t1;
		t1 = cyc;
	endtask : wait_irq
	task automatic print_verdict();
		if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	initial begin
		#1000000;
		n_errors++;
		print_verdict();
	end
	// ====
	// main sequence
	initial begin
		rst = 1'b1;
		raw = 24'h123456;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		foreach (rows[i]) begin
			if (rows[i].w) host.wr(rows[i].a, rows[i].d);
			host.rd(rows[i].a, v);
			chk("reg", rows[i].e, v);
		end
		// one shot to standby, selector drives the input
		host.wr(OFS_THIRD_CONFIG_REGISTER, 24'h000080);
		host.wr(OFS_ADC_MODE, 24'h000003);
		t1 = cyc;
		chk("mux_sel", 24'h00005a, {16'h0000, input_selector});
		wait_irq();
		chk_rng("conv_time", 500, 530, t1 - t0);
		repeat (100) @(negedge clk);
		chk("irq_held", 24'h000000, {23'h000000, irq_n});
		chk("mode", {22'h000000, MODE_STANDBY}, {22'h000000, mode});
		host.rd(OFS_RESULT, v);
		chk("result", 24'h123456, v);
		chk("irq_clr", 24'h000001, {23'h000000, irq_n});
		// restart with input swap, ends in shutdown
		host.wr(OFS_THIRD_CONFIG_REGISTER, 24'h000004);
		host.restart();
		t1 = cyc;
		wait_irq();
		chk_rng("az_time", 1010, 1045, t1 - t0);
		chk("mode", {22'h000000, MODE_SHUTDOWN}, {22'h000000, mode});
		host.rd(OFS_RESULT, v);
		// gain trim at half, then quarter
		host.wr(OFS_THIRD_CONFIG_REGISTER, 24'h000081);
		host.rd(OFS_RESULT, v);
		chk("held", 24'h123456, v);
		host.wr(OFS_ADC_MODE, 24'h000003);
		t1 = cyc;
		wait_irq();
		chk_rng("trim_time", 680, 712, t1 - t0);
		host.rd(OFS_RESULT, v);
		chk("trim", 24'h091a2b, v);
		host.wr(OFS_GAIN, 24'h200000);
		host.rd(OFS_RESULT, v);
		chk("held2", 24'h091a2b, v);
		host.wr(OFS_ADC_MODE, 24'h000003);
		wait_irq();
		host.rd(OFS_RESULT, v);
		chk("trim2", 24'h048d15, v);
		// continuous with trim, config rewritten mid-conversion
		host.wr(OFS_THIRD_CONFIG_REGISTER, 24'h0000c1);
		host.wr(OFS_ADC_MODE, 24'h000003);
		t1 = cyc;
		wait_irq();
		chk_rng("first", 680, 712, t1 - t0);
		n0 = nfr;
		repeat (200) @(negedge clk);
		host.wr(OFS_THIRD_CONFIG_REGISTER, 24'h0000c1);
		wait_irq();
		chk_rng("rate", 504, 520, t1 - t0);
		wait_irq();
		chk_rng("rate2", 504, 520, t1 - t0);
		chk("no_freset", 24'(n0), 24'(nfr));
		host.wr(OFS_ADC_MODE, 24'h000000);
		// stopping does not clear data ready, so the pending result is read out
		host.rd(OFS_RESULT, v);
		chk("cont_res", 24'h048d15, v);
		// continuous with input swap: reset between shots, doubled spacing
		host.wr(OFS_THIRD_CONFIG_REGISTER, 24'h0000c4);
		host.wr(OFS_ADC_MODE, 24'h000003);
		wait_irq();
		n0 = nfr;
		wait_irq();
		chk_rng("az_rate", 1016, 1032, t1 - t0);
		chk("az_freset", 24'(n0 + 1), 24'(nfr));
		host.wr(OFS_ADC_MODE, 24'h000000);
		host.rd(OFS_RESULT, v);
		// scan of three channels, repeated, with intra-cycle wait, then cycle timer
		host.wr(OFS_THIRD_CONFIG_REGISTER, 24'h0000c0);
		host.wr(OFS_SCAN, 24'h108101);
		host.wr(OFS_ADC_MODE, 24'h000003);
		t1 = cyc;
		@(negedge clk);
		chk("first_ch", 24'h000088, {16'h0000, input_selector});
		for (int i = 0; i < 7; i++) begin
			wait_irq();
			chk_rng("spacing", sp[i] - 10, sp[i] + 12, t1 - t0);
			chk("next_ch", {16'h0000, nx[i]}, {16'h0000, input_selector});
			chk("mode", {22'h000000, MODE_CONVERT}, {22'h000000, mode});
			host.rd(OFS_RESULT, v);
			chk("scan_res", 24'h123456, v);
			// second cycle ends in a timed wait, channel kept until it runs out
			if (i == 2) host.wr(OFS_TIMER, 24'h000010);
		end
		host.wr(OFS_ADC_MODE, 24'h000002);
		host.wr(OFS_SCAN, 24'h000000);
		// reset in mid-conversion brings back the power-up values
		host.wr(OFS_ADC_MODE, 24'h000003);
		repeat (50) @(negedge clk);
		chk("conv", 24'h000001, {23'h000000, conv});
		rst = 1'b1;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk("rst_out", {14'h0000, 1'b0, 8'h01, 1'b1}, {14'h0000, conv, input_selector, irq_n});
		chk("rst_mode", 24'h000000, {22'h000000, mode});
		host.rd(OFS_GAIN, v);
		chk("rst_gain", 24'h800000, v);
		host.rd(OFS_THIRD_CONFIG_REGISTER, v);
		chk("rst_cfg", 24'h000000, v);
		print_verdict();
	end
endmodule : adc_conversion_sequencer_tb
